// *** idw_pkg.sv ***
// constants and types shared by the identify parameter block
package idw_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_GEOM = 8'h04;
   localparam logic [7:0] OFF_SPT = 8'h08;
   localparam logic [7:0] OFF_CAP = 8'h0c;
   localparam logic [7:0] OFF_UDMA = 8'h10;
   localparam logic [7:0] OFF_CMD = 8'h14;
   localparam logic [7:0] OFF_DATA = 8'h18;
   localparam logic [7:0] OFF_STAT = 8'h1c;
   // control fields
   localparam int CTRL_CARD_BIT = 0;
   localparam int CTRL_STYLE_LSB = 1;
   localparam int CTRL_RMED_BIT = 3;
   localparam int CTRL_FIXED_BIT = 4;
   localparam int CTRL_KEEP_BIT = 5;
   localparam logic [31:0] CTRL_MASK = 32'h0000_003f;
   // geometry / timing fields
   localparam int GEOM_HEADS_LSB = 16;
   localparam int SPT_PIO_LSB = 16;
   localparam int UDMA_SEL_LSB = 8;
   localparam logic [7:0] PIO_MODE_MAX = 8'h02;
   // status fields
   localparam int STAT_DRQ_BIT = 0;
   localparam int STAT_ABORT_BIT = 1;
   localparam int STAT_UNDER_BIT = 2;
   localparam int STAT_IDX_LSB = 8;
   // reset values, identify command code and last word index
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [15:0] CYL_RST = 16'h0000;
   localparam logic [7:0] HEADS_RST = 8'h00;
   localparam logic [15:0] SPT_RST = 16'h0000;
   localparam logic [7:0] PIO_RST = 8'h00;
   localparam logic [31:0] CAP_RST = 32'h0000_0000;
   localparam logic [7:0] UDMA_RST = 8'h00;
   localparam logic [7:0] CMD_IDENTIFY = 8'hec;
   localparam logic [7:0] LAST_WORD = 8'hff;
   // word 0 encodings
   localparam logic [15:0] W0_ALT_KEEP = 16'h044a;
   localparam logic [15:0] W0_ALT_ZERO = 16'h0040;
   localparam logic [3:0] W0_FLAG_FIELDS = 4'h0;
   localparam logic [3:0] W0_RET_KEEP = 4'h4;
   localparam logic [3:0] W0_RET_ZERO = 4'h0;
   localparam logic [5:0] W0_LOW_KEEP = 6'h0a;
   localparam logic [5:0] W0_LOW_ZERO = 6'h00;
   // fixed word contents
   localparam logic [15:0] ECC_COUNT = 16'h0004;
   localparam logic [15:0] MULT_MAX = 16'h8001;
   localparam logic [15:0] CAPAB_VAL = 16'h0200;
   localparam logic [15:0] VALID_VAL = 16'h0001;
   localparam logic [15:0] MULT_SET = 16'h0100;
   localparam logic [15:0] MWDMA_VAL = 16'h0000;
   localparam logic [15:0] ADV_PIO_VAL = 16'h0000;
   localparam logic [15:0] MWDMA_MIN_NS = 16'h0000;
   localparam logic [15:0] MWDMA_REC_NS = 16'h0000;
   localparam logic [15:0] PIO_MIN_NS = 16'h0078;
   localparam logic [15:0] PIO_IORDY_NS = 16'h0078;
   localparam logic [15:0] W83_CMDSET = 16'h0004;
   typedef enum logic [1:0] {STYLE_SIG, STYLE_ALT_KEEP, STYLE_ALT_ZERO, STYLE_FIELDS}
      word0_style_t;
   typedef enum logic {ST_IDLE, ST_DRQ} xfer_state_t;
endpackage : idw_pkg

// *** idw_cfg_if.sv ***
// configuration carried from the register file to the word generators
`timescale 1ns/1ps
interface idw_cfg_if;
   logic card_mode;
   logic [15:0] cyl;
   logic [7:0] heads;
   logic [15:0] spt;
   logic [7:0] pio_mode;
   logic [31:0] capacity;
   logic [7:0] udma_sup;
   logic [7:0] udma_sel;
   logic [15:0] word0;
   modport src (output card_mode, cyl, heads, spt, pio_mode, capacity, udma_sup, udma_sel,
      input word0);
   modport w0 (input card_mode, output word0);
   modport snk (input card_mode, cyl, heads, spt, pio_mode, capacity, udma_sup, udma_sel,
      word0);
endinterface : idw_cfg_if

// *** idw_word0.sv ***
// general configuration word encoder
`timescale 1ns/1ps
module idw_word0
   import idw_pkg::*;
(
   // selection
   input word0_style_t style,
   input wire logic removable_media,
   input wire logic fixed_card,
   input wire logic keep_pattern,
   // result
   idw_cfg_if.w0 cfg
);
   // arbitrary neutral signature value
   parameter logic [15:0] SIG_WORD = 16'h8040;
   logic [15:0] fields;

   always_comb
   begin
      fields = {W0_FLAG_FIELDS,
         keep_pattern ? W0_RET_KEEP : W0_RET_ZERO,
         removable_media,
         fixed_card,
         keep_pattern ? W0_LOW_KEEP : W0_LOW_ZERO};
      // memory-card bus always reports the signature word, whatever the style
      if (cfg.card_mode)
         cfg.word0 = SIG_WORD;
      else
      begin
         case (style)
            STYLE_SIG: cfg.word0 = SIG_WORD;
            STYLE_ALT_KEEP: cfg.word0 = W0_ALT_KEEP;
            STYLE_ALT_ZERO: cfg.word0 = W0_ALT_ZERO;
            STYLE_FIELDS: cfg.word0 = fields;
            default: cfg.word0 = SIG_WORD;
         endcase
      end
   end
endmodule : idw_word0

// *** idw_content.sv ***
// parameter word content selected by word index
`timescale 1ns/1ps
module idw_content
   import idw_pkg::*;
(
   // selection
   input wire logic [7:0] idx,
   idw_cfg_if.snk cfg,
   // result
   output logic [15:0] word
);
   always_comb
   begin
      case (idx)
         8'h00: word = cfg.word0;
         8'h01: word = cfg.cyl;
         8'h03: word = {8'h00, cfg.heads};
         8'h06: word = cfg.spt;
         8'h07: word = cfg.capacity[31:16];
         8'h08: word = cfg.capacity[15:0];
         8'h16: word = ECC_COUNT;
         8'h2f: word = MULT_MAX;
         8'h31: word = CAPAB_VAL;
         8'h33: word = {cfg.pio_mode, 8'h00};
         8'h35: word = VALID_VAL;
         8'h36: word = cfg.cyl;
         8'h37: word = {8'h00, cfg.heads};
         8'h38: word = cfg.spt;
         8'h39: word = cfg.capacity[15:0];
         8'h3a: word = cfg.capacity[31:16];
         8'h3b: word = MULT_SET;
         8'h3c: word = cfg.capacity[15:0];
         8'h3d: word = cfg.capacity[31:16];
         8'h3f: word = cfg.card_mode ? 16'h0000 : MWDMA_VAL;
         8'h40: word = ADV_PIO_VAL;
         8'h41: word = cfg.card_mode ? 16'h0000 : MWDMA_MIN_NS;
         8'h42: word = cfg.card_mode ? 16'h0000 : MWDMA_REC_NS;
         8'h43: word = PIO_MIN_NS;
         8'h44: word = PIO_IORDY_NS;
         8'h53: word = W83_CMDSET;
         8'h56: word = W83_CMDSET;
         8'h58: word = {cfg.udma_sel, cfg.udma_sup};
         // words 80-81, 161, 165-175 and all other reserved words
         default: word = 16'h0000;
      endcase
   end
endmodule : idw_content

// *** idw_top.sv ***
// identify parameter block with apb register access
`timescale 1ns/1ps
module idw_top
   import idw_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // transfer status
   output logic drq
);
   idw_cfg_if cfg ();

   logic [31:0] ctrl_reg;
   logic [31:0] geom_reg;
   logic [31:0] spt_reg;
   logic [31:0] cap_reg;
   logic [31:0] udma_reg;
   logic [31:0] prdata_reg;
   logic [7:0] idx_reg;
   logic abort_reg;
   logic under_reg;
   xfer_state_t state_reg;
   logic [15:0] cur_word;
   logic [31:0] rd_value;
   logic addr_ok;
   logic wr_acc;
   logic rd_acc;
   logic setup;
   logic wr_ctrl;
   logic wr_geom;
   logic wr_spt;
   logic wr_cap;
   logic wr_udma;
   logic wr_cmd;
   logic wr_stat;
   logic rd_data;
   logic [7:0] pio_req;
   logic [31:0] spt_merged;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
            res[i*8 +: 8] = nw[i*8 +: 8];
      end
      return res;
   endfunction : merge

   ////////////////////////////////////////////////////////////////////////////////
   // apb decode

   always_comb
   begin
      case (paddr)
         OFF_CTRL, OFF_GEOM, OFF_SPT, OFF_CAP, OFF_UDMA, OFF_CMD, OFF_DATA, OFF_STAT:
            addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // zero wait states: every access completes in its first access cycle
   assign pready = psel & penable;
   assign pslverr = psel & penable & ~addr_ok;
   assign setup = psel & ~penable;
   assign wr_acc = psel & penable & pwrite & addr_ok;
   assign rd_acc = psel & penable & ~pwrite & addr_ok;
   assign wr_ctrl = wr_acc & (paddr == OFF_CTRL);
   assign wr_geom = wr_acc & (paddr == OFF_GEOM);
   assign wr_spt = wr_acc & (paddr == OFF_SPT);
   assign wr_cap = wr_acc & (paddr == OFF_CAP);
   assign wr_udma = wr_acc & (paddr == OFF_UDMA);
   assign wr_cmd = wr_acc & (paddr == OFF_CMD) & pstrb[0];
   assign wr_stat = wr_acc & (paddr == OFF_STAT) & pstrb[0];
   assign rd_data = rd_acc & (paddr == OFF_DATA);
   assign prdata = prdata_reg;
   assign drq = (state_reg == ST_DRQ);

   ////////////////////////////////////////////////////////////////////////////////
   // configuration registers

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ctrl_reg <= CTRL_RST;
      else if (wr_ctrl)
         ctrl_reg <= merge(ctrl_reg, pwdata, pstrb) & CTRL_MASK;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         geom_reg <= {8'h00, HEADS_RST, CYL_RST};
      else if (wr_geom)
         geom_reg <= merge(geom_reg, pwdata, pstrb) & 32'h00ff_ffff;
   end

   // reserved pio modes are refused by saturating to the fastest legal one
   assign pio_req = pwdata[SPT_PIO_LSB +: 8] > PIO_MODE_MAX ? PIO_MODE_MAX
      : pwdata[SPT_PIO_LSB +: 8];
   assign spt_merged = merge(spt_reg, pwdata, pstrb);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         spt_reg <= {8'h00, PIO_RST, SPT_RST};
      else if (wr_spt)
      begin
         spt_reg[15:0] <= spt_merged[15:0];
         if (pstrb[2])
            spt_reg[SPT_PIO_LSB +: 8] <= pio_req;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         cap_reg <= CAP_RST;
      else if (wr_cap)
         cap_reg <= merge(cap_reg, pwdata, pstrb);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         udma_reg <= {16'h0000, UDMA_RST, UDMA_RST};
      else if (wr_udma)
         udma_reg <= merge(udma_reg, pwdata, pstrb) & 32'h0000_ffff;
   end

   assign cfg.card_mode = ctrl_reg[CTRL_CARD_BIT];
   assign cfg.cyl = geom_reg[15:0];
   assign cfg.heads = geom_reg[GEOM_HEADS_LSB +: 8];
   assign cfg.spt = spt_reg[15:0];
   assign cfg.pio_mode = spt_reg[SPT_PIO_LSB +: 8];
   assign cfg.capacity = cap_reg;
   assign cfg.udma_sup = udma_reg[7:0];
   assign cfg.udma_sel = udma_reg[UDMA_SEL_LSB +: 8];

   ////////////////////////////////////////////////////////////////////////////////
   // word generation

   idw_word0 u_word0 (
      .style(word0_style_t'(ctrl_reg[CTRL_STYLE_LSB +: 2])),
      .removable_media(ctrl_reg[CTRL_RMED_BIT]),
      .fixed_card(ctrl_reg[CTRL_FIXED_BIT]),
      .keep_pattern(ctrl_reg[CTRL_KEEP_BIT]),
      .cfg(cfg.w0)
   );

   idw_content u_content (
      .idx(idx_reg),
      .cfg(cfg.snk),
      .word(cur_word)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // identify transfer sequencing

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_reg <= ST_IDLE;
         idx_reg <= 8'h00;
      end
      else if (wr_cmd)
      begin
         // a new identify restarts from word 0; anything else ends the transfer
         if (pwdata[7:0] == CMD_IDENTIFY)
         begin
            state_reg <= ST_DRQ;
            idx_reg <= 8'h00;
         end
         else
            state_reg <= ST_IDLE;
      end
      else if (rd_data && state_reg == ST_DRQ)
      begin
         // one sector of 256 words, in ascending order
         idx_reg <= idx_reg + 8'h01;
         if (idx_reg == LAST_WORD)
            state_reg <= ST_IDLE;
      end
   end

   // sticky error flags; a new event beats a simultaneous write-one clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         abort_reg <= 1'b0;
      else if (wr_cmd && pwdata[7:0] != CMD_IDENTIFY)
         abort_reg <= 1'b1;
      else if (wr_stat && pwdata[STAT_ABORT_BIT])
         abort_reg <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         under_reg <= 1'b0;
      else if (rd_data && state_reg == ST_IDLE)
         under_reg <= 1'b1;
      else if (wr_stat && pwdata[STAT_UNDER_BIT])
         under_reg <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read data, captured in the setup cycle and held through the access

   always_comb
   begin
      rd_value = 32'h0000_0000;
      case (paddr)
         OFF_CTRL: rd_value = ctrl_reg;
         OFF_GEOM: rd_value = geom_reg;
         OFF_SPT: rd_value = spt_reg;
         OFF_CAP: rd_value = cap_reg;
         OFF_UDMA: rd_value = udma_reg;
         OFF_DATA: rd_value = drq ? {16'h0000, cur_word} : 32'h0000_0000;
         OFF_STAT:
         begin
            rd_value[STAT_DRQ_BIT] = drq;
            rd_value[STAT_ABORT_BIT] = abort_reg;
            rd_value[STAT_UNDER_BIT] = under_reg;
            rd_value[STAT_IDX_LSB +: 8] = idx_reg;
         end
         default: rd_value = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata_reg <= 32'h0000_0000;
      else if (setup && !pwrite)
         prdata_reg <= rd_value;
   end
endmodule : idw_top

// *** idw_checker.sv ***
// assertions on the identify block's apb port and transfer flag
`timescale 1ns/1ps
module idw_checker
   import idw_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // status
   input wire logic drq
);
   logic acc, cmd_wr, id_wr, data_rd, kill, mapped;
   logic [8:0] rd_cnt;
   assign acc = psel && penable;
   assign cmd_wr = acc && pwrite && paddr == OFF_CMD && pstrb[0];
   assign id_wr = cmd_wr && pwdata[7:0] == CMD_IDENTIFY;
   assign data_rd = acc && !pwrite && paddr == OFF_DATA;
   assign kill = cmd_wr || data_rd;
   assign mapped = paddr <= OFF_STAT && paddr[1:0] == 2'b00;
   // data reads made while drq is high since the last command, any command restarts the count
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         rd_cnt <= 9'd0;
      else if (cmd_wr)
         rd_cnt <= 9'd0;
      else if (data_rd && drq)
         rd_cnt <= rd_cnt + 9'd1;
   end
   ////////////////////////////////////////
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_idle_data;
      psel && !penable && !pwrite && paddr == OFF_DATA && !drq ##1 acc;
   endsequence
   sequence s_last_read;
      data_rd && drq && rd_cnt == 9'd255;
   endsequence
   a_ready_access: assert property (acc |-> pready)
      else $error("pready low in access");
   a_setup_wait: assert property (psel && !penable |-> !pready)
      else $error("pready high in setup");
   a_unmapped_err: assert property (acc && !mapped |-> pslverr)
      else $error("no error on unmapped address");
   a_mapped_ok: assert property (acc && mapped |-> !pslverr)
      else $error("error on mapped address");
   a_ident_start: assert property (id_wr |=> drq)
      else $error("identify did not start");
   a_abort_stop: assert property (cmd_wr && !id_wr |=> !drq)
      else $error("other command left transfer running");
   a_start_cause: assert property ($rose(drq) |-> $past(id_wr))
      else $error("transfer began without command");
   a_fall_cause: assert property ($fell(drq) |-> $past(kill))
      else $error("transfer ended without cause");
   a_idle_zero: assert property (s_idle_data |-> prdata == 32'h0)
      else $error("idle data read not zero");
   a_last_word: assert property (s_last_read |=> !drq)
      else $error("transfer longer than 256 words");
   a_early_word: assert property (data_rd && drq && rd_cnt < 9'd255 |=> drq)
      else $error("transfer shorter than 256 words");
endmodule : idw_checker

bind idw_top idw_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .drq(drq));

// *** apb_host.sv ***
// apb master standing in for the host controller
`timescale 1ns/1ps
module apb_host
(
   // clock
   input wire logic pclk,
   // apb master
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [7:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   logic [1:0] gap;
   initial
   begin
      gap = 2'd0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pstrb = 4'h0;
   end
   ////////////////////////////////////////
   // setup then access, held until pready is seen high at an edge
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] q, output logic e);
      repeat (gap + 1) @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      // only the bench timeout ends a wait that never sees pready
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines show garbage, not the old request
      paddr <= ~a;
      pwdata <= ~d;
      pstrb <= 4'h0;
   endtask : xfer
endmodule : apb_host

// *** tb_identify_device_parameter_block.sv ***
// self-checking bench for the identify parameter block
`timescale 1ns/1ps
module tb_identify_device_parameter_block;
   import idw_pkg::*;
   // arbitrary signature, the encoder's default
   localparam logic [15:0] SIG = 16'h8040;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, drq, e;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] pstrb;
   logic [31:0] cfg [5];
   int err_total = 0;
   int check_count = 0;
   int seed = 32'h3da6;
   int cycles = 0;
   always #2 pclk = ~pclk;
   idw_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .drq(drq));
   apb_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   ////////////////////////////////////////
   task automatic stop_test();
      if (err_total == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      host.xfer(1'b1, a, d, 4'hf, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a);
      host.xfer(1'b0, a, 32'h0, 4'h0, q, e);
   endtask : rd
   function automatic logic [15:0] exp_word(input int i);
      logic [15:0] w0;
      logic k;
      k = cfg[0][5];
      case (cfg[0][2:1])
         2'd1: w0 = 16'h044a;
         2'd2: w0 = 16'h0040;
         2'd3: w0 = {4'h0, k ? 4'h4 : 4'h0, cfg[0][3], cfg[0][4], k ? 6'h0a : 6'h00};
         default: w0 = SIG;
      endcase
      if (cfg[0][0])
         w0 = SIG;
      case (i)
         0: return w0;
         1, 54: return cfg[1][15:0];
         3, 55: return {8'h00, cfg[1][23:16]};
         6, 56: return cfg[2][15:0];
         7, 58, 61: return cfg[3][31:16];
         8, 57, 60: return cfg[3][15:0];
         22: return 16'h0004;
         47: return 16'h8001;
         49: return 16'h0200;
         51: return {cfg[2][23:16], 8'h00};
         53: return 16'h0001;
         59: return 16'h0100;
         67, 68: return 16'h0078;
         83, 86: return 16'h0004;
         88: return cfg[4][15:0];
         default: return 16'h0000;
      endcase
   endfunction : exp_word
   task automatic load_config(input logic [5:0] ctrl);
      logic [31:0] raw;
      raw = $random(seed) & 32'h00ff_ffff;
      cfg[0] = {26'h0, ctrl};
      cfg[1] = $random(seed) & 32'h00ff_ffff;
      cfg[2] = raw;
      if (raw[23:16] > 8'h02)
         cfg[2][23:16] = 8'h02;
      cfg[3] = $random(seed);
      cfg[4] = $random(seed) & 32'h0000_ffff;
      host.gap = 2'($random(seed));
      for (int k = 0; k < 5; k++)
      begin
         wr(8'(4 * k), k == 2 ? raw : cfg[k]);
         rd(8'(4 * k));
         check("register", q, cfg[k]);
      end
   endtask : load_config
   task automatic run_identify(input int n);
      wr(OFF_CMD, 32'h0000_00ec);
      for (int i = 0; i < n; i++)
      begin
         #1 check("drq", {31'h0, drq}, 32'h1);
         rd(OFF_DATA);
         if (i == 0)
            check("word0", q, {16'h0, exp_word(i)});
         else
            check("word", q, {16'h0, exp_word(i)});
      end
      #1 check("drq", {31'h0, drq}, {31'h0, n < 256});
   endtask : run_identify
   ////////////////////////////////////////
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         err_total++;
         stop_test();
      end
   end
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int k = 0; k < 8; k++)
      begin
         rd(8'(4 * k));
         // the idle data read just before sets the sticky underrun bit
         check("reset value", q, k == 7 ? 32'h0000_0004 : 32'h0);
      end
      rd(8'h20);
      check("unmapped", {31'h0, e}, 32'h1);
      host.xfer(1'b1, OFF_CMD, 32'h0000_00ec, 4'he, q, e);
      #1 check("drq", {31'h0, drq}, 32'h0);
      // word 0 styles with field bits, card mode at k == 6
      for (int k = 0; k < 8; k++)
      begin
         load_config({k[2], 2'($random(seed)), k[1:0], k == 6});
         run_identify(256);
      end
      run_identify(10);
      run_identify(1);
      wr(OFF_CMD, 32'h0);
      #1 check("drq", {31'h0, drq}, 32'h0);
      rd(OFF_DATA);
      check("idle data", q, 32'h0);
      rd(OFF_STAT);
      check("status", {29'h0, q[2:0]}, 32'h6);
      wr(OFF_STAT, 32'h6);
      rd(OFF_STAT);
      check("status", {29'h0, q[2:0]}, 32'h0);
      stop_test();
   end
endmodule : tb_identify_device_parameter_block
